/* File: adc_chop_frontend.sv */
`timescale 1ns/100ps
module adc_chop_frontend import adc_chop_pkg::*; #(
    parameter int SAMPLE_WIDTH = 16,
    parameter int ADC_CLK_KHZ = ADC_CLK_KHZ_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic startPin,
    input wire logic csPin_n,
    input wire logic sclkPin,
    input wire logic dinPin,
    output logic doutPin,
    output logic doutEn,
    output logic drdyPin_n,
    input wire logic signed [SAMPLE_WIDTH-1:0] convSample,
    output logic signed [SAMPLE_WIDTH-1:0] dataOut,
    output logic dataReady,
    output logic converting,
    output frontend_t frontend
);
    localparam int ACC_W = 20;

    if (SAMPLE_WIDTH < 2 || SAMPLE_WIDTH > 32) begin : g_width_check
        $error("SAMPLE_WIDTH must lie between 2 and 32");
    end
    if (ADC_CLK_KHZ < 1 || ADC_CLK_KHZ >= TICK_LIMIT) begin : g_clk_check
        $error("ADC_CLK_KHZ must be positive and below sys_clk times 16");
    end

    // Reset release through two flops
    logic rstMeta_q, rstSync_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // Start pin is asynchronous to sys_clk
    logic startMeta_q, startSync_q, startPrev_q, startEdge;
    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            startMeta_q <= 1'b0;
            startSync_q <= 1'b0;
            startPrev_q <= 1'b0;
        end else if (clkEn) begin
            startMeta_q <= startPin;
            startSync_q <= startMeta_q;
            startPrev_q <= startSync_q;
        end
    end
    assign startEdge = startSync_q && !startPrev_q;

    serial_req_t req;
    logic [7:0] rdData;

    serial_port u_serial (
        .sys_clk(sys_clk),
        .rstSync_n(rstSync_q),
        .clkEn(clkEn),
        .csPin_n(csPin_n),
        .sclkPin(sclkPin),
        .dinPin(dinPin),
        .rdData(rdData),
        .doutPin(doutPin),
        .doutEn(doutEn),
        .req(req)
    );

    // Configuration registers
    logic [7:0] gain_q, gain_d, drate_q, drate_d, exc1_q, exc1_d;
    logic [7:0] exc2_q, exc2_d, bias_q, bias_d, sys_q, sys_d;

    function automatic logic [7:0] regRead(
        input logic [4:0] addr,
        input logic [7:0] g, d, e1, e2, b, s
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            REG_GAIN: v = g;
            REG_DRATE: v = d;
            REG_EXC1: v = e1;
            REG_EXC2: v = e2;
            REG_BIAS: v = b;
            REG_SYS: v = s;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : regRead

    assign rdData = regRead(req.addr, gain_q, drate_q, exc1_q, exc2_q,
        bias_q, sys_q);

    always_comb begin
        gain_d = gain_q;
        drate_d = drate_q;
        exc1_d = exc1_q;
        exc2_d = exc2_q;
        bias_d = bias_q;
        sys_d = sys_q;
        if (req.wrEn) begin
            case (req.addr)
                REG_GAIN: gain_d = req.wrData;
                REG_DRATE: drate_d = req.wrData;
                REG_EXC1: exc1_d = req.wrData;
                REG_EXC2: exc2_d = req.wrData;
                REG_BIAS: bias_d = req.wrData;
                REG_SYS: sys_d = req.wrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            gain_q <= GAIN_RST;
            drate_q <= DRATE_RST;
            exc1_q <= EXC1_RST;
            exc2_q <= EXC2_RST;
            bias_q <= BIAS_RST;
            sys_q <= SYS_RST;
        end else if (clkEn) begin
            gain_q <= gain_d;
            drate_q <= drate_d;
            exc1_q <= exc1_d;
            exc2_q <= exc2_d;
            bias_q <= bias_d;
            sys_q <= sys_d;
        end
    end

    // Modulator period tick; fractional so any ADC clock divides evenly
    logic [ACC_W-1:0] acc_q, acc_d;
    logic modTick;
    always_comb begin
        acc_d = acc_q + ACC_W'(ADC_CLK_KHZ);
        modTick = acc_d >= ACC_W'(TICK_LIMIT);
        if (modTick) begin
            acc_d = acc_d - ACC_W'(TICK_LIMIT);
        end
    end
    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            acc_q <= '0;
        end else if (clkEn) begin
            acc_q <= acc_d;
        end
    end

    // Codes past the table fall back to the fastest rate
    function automatic int rateIndex(input logic [3:0] code);
        return (int'(code) < RATE_CODES) ? int'(code) : RATE_CODES - 1;
    endfunction : rateIndex

    function automatic logic signed [SAMPLE_WIDTH-1:0] chopAverage(
        input logic signed [SAMPLE_WIDTH-1:0] cur,
        input logic signed [SAMPLE_WIDTH-1:0] prev,
        input logic curReversed
    );
        logic signed [SAMPLE_WIDTH:0] normal, flipped, total;
        normal = curReversed ? prev : cur;
        flipped = curReversed ? cur : prev;
        total = normal - flipped;
        return total[SAMPLE_WIDTH:1];
    endfunction : chopAverage

    // Conversion sequencer
    logic chopOn, lowLat, singleShot, trigger;
    logic [19:0] convLen, periodLen, delayLen;
    int rateIdx;
    seq_state_t state_q, state_d;
    logic [19:0] cnt_q, cnt_d;
    logic reversed_q, reversed_d, haveFirst_q, haveFirst_d;
    logic signed [SAMPLE_WIDTH-1:0] prev_q, prev_d, data_q, data_d;
    logic ready_q, ready_d, drdy_q, drdy_d;

    assign chopOn = drate_q[DR_CHOP_BIT];
    assign lowLat = drate_q[DR_LOWLAT_BIT];
    assign singleShot = drate_q[DR_SINGLE_BIT];
    assign rateIdx = rateIndex(drate_q[DR_RATE_LSB +: 4]);
    // Sinc3 lengths already span three settling periods
    assign convLen = lowLat ? LL_FIRST[rateIdx] : SINC_FIRST[rateIdx];
    assign periodLen = DATA_PERIOD[rateIdx];
    assign delayLen = DELAY_TICKS[gain_q[GAIN_DELAY_LSB +: 3]];
    assign trigger = startEdge || req.startCmd;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        reversed_d = reversed_q;
        haveFirst_d = haveFirst_q;
        prev_d = prev_q;
        data_d = data_q;
        ready_d = 1'b0;
        drdy_d = drdy_q;
        if (trigger) begin
            // Restart discards any half-finished chop pair
            state_d = SEQ_SETTLE;
            cnt_d = delayLen;
            reversed_d = 1'b0;
            haveFirst_d = 1'b0;
            drdy_d = 1'b1;
        end else if (modTick) begin
            case (state_q)
                SEQ_SETTLE: begin
                    if (cnt_q > 20'h00001) begin
                        cnt_d = cnt_q - 20'h00001;
                    end else begin
                        state_d = SEQ_SAMPLE;
                        cnt_d = convLen;
                    end
                end
                SEQ_SAMPLE: begin
                    if (cnt_q > 20'h00001) begin
                        cnt_d = cnt_q - 20'h00001;
                    end else if (chopOn) begin
                        prev_d = convSample;
                        reversed_d = !reversed_q;
                        haveFirst_d = 1'b1;
                        state_d = SEQ_SETTLE;
                        cnt_d = delayLen;
                        if (haveFirst_q) begin
                            data_d = chopAverage(convSample, prev_q,
                                reversed_q);
                            ready_d = 1'b1;
                            drdy_d = 1'b0;
                            if (singleShot) begin
                                state_d = SEQ_IDLE;
                                reversed_d = 1'b0;
                            end
                        end
                    end else begin
                        data_d = convSample;
                        ready_d = 1'b1;
                        drdy_d = 1'b0;
                        state_d = singleShot ? SEQ_IDLE : SEQ_SAMPLE;
                        cnt_d = periodLen;
                    end
                end
                default: state_d = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q <= SEQ_IDLE;
            cnt_q <= '0;
            reversed_q <= 1'b0;
            haveFirst_q <= 1'b0;
            prev_q <= '0;
            data_q <= '0;
            ready_q <= 1'b0;
            drdy_q <= 1'b1;
        end else if (clkEn) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            reversed_q <= reversed_d;
            haveFirst_q <= haveFirst_d;
            prev_q <= prev_d;
            data_q <= data_d;
            ready_q <= ready_d;
            drdy_q <= drdy_d;
        end
    end

    // Front-end settings; reference enable stays the host's job
    frontend_t fe_q, fe_d;
    always_comb begin
        fe_d.excitationMagnitude = exc1_q[EXC1_MAG_LSB +: 4];
        fe_d.firstSourceRoute = exc2_q[EXC2_FIRST_LSB +: 4];
        fe_d.secondSourceRoute = exc2_q[EXC2_SECOND_LSB +: 4];
        fe_d.biasTwelfth = bias_q[BIAS_LEVEL_BIT];
        fe_d.biasPinEnables = bias_q[BIAS_PINS_LSB +: 7];
        fe_d.monitorSelect = sys_q[SYS_MON_LSB +: 3];
        // Gain is not forwarded here; only its delay field is used, to set the settle time
        fe_d.tempSensorOn = sys_q[SYS_MON_LSB +: 3] == MON_TEMP;
        fe_d.inputsConnected = sys_q[SYS_MON_LSB +: 3] != MON_TEMP;
        fe_d.polarityReversed = reversed_d;
    end
    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            fe_q <= '0;
        end else if (clkEn) begin
            fe_q <= fe_d;
        end
    end

    assign frontend = fe_q;
    assign dataOut = data_q;
    assign dataReady = ready_q;
    assign drdyPin_n = drdy_q;
    assign converting = state_q != SEQ_IDLE;

endmodule : adc_chop_frontend

/* File: adc_chop_pkg.sv */
package adc_chop_pkg;

    // Register indices on the serial port
    localparam logic [4:0] REG_GAIN = 5'h03;
    localparam logic [4:0] REG_DRATE = 5'h04;
    localparam logic [4:0] REG_EXC1 = 5'h06;
    localparam logic [4:0] REG_EXC2 = 5'h07;
    localparam logic [4:0] REG_BIAS = 5'h08;
    localparam logic [4:0] REG_SYS = 5'h09;

    // Reset values
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [7:0] DRATE_RST = 8'h14;
    localparam logic [7:0] EXC1_RST = 8'h00;
    localparam logic [7:0] EXC2_RST = 8'hFF;
    localparam logic [7:0] BIAS_RST = 8'h00;
    localparam logic [7:0] SYS_RST = 8'h10;

    // Field positions
    localparam int GAIN_DELAY_LSB = 5;
    localparam int DR_CHOP_BIT = 7;
    localparam int DR_SINGLE_BIT = 5;
    localparam int DR_LOWLAT_BIT = 4;
    localparam int DR_RATE_LSB = 0;
    localparam int EXC1_MAG_LSB = 0;
    localparam int EXC2_FIRST_LSB = 0;
    localparam int EXC2_SECOND_LSB = 4;
    localparam int BIAS_LEVEL_BIT = 7;
    localparam int BIAS_PINS_LSB = 0;
    localparam int SYS_MON_LSB = 5;
    localparam logic [2:0] MON_TEMP = 3'h2;

    // Serial opcodes
    localparam logic [7:0] OP_START = 8'h08;
    localparam logic [2:0] OP_RREG_TOP = 3'h1;
    localparam logic [2:0] OP_WREG_TOP = 3'h2;

    // Clocking: modulator period is 16 ADC clocks
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int SYS_CLK_KHZ = 1000000 / SYS_CLK_PERIOD_NS;
    localparam int ADC_CLK_KHZ_DEF = 4096;
    localparam int MOD_CLKS = 16;
    localparam int TICK_LIMIT = SYS_CLK_KHZ * MOD_CLKS;

    // Times in modulator periods, per data rate code 0 (2.5) .. 13 (4000)
    localparam int RATE_CODES = 14;
    localparam logic [19:0] LL_FIRST [RATE_CODES] = '{
        20'h19681, 20'h0CE81, 20'h06A81, 20'h03C41, 20'h03881, 20'h01428,
        20'h010E9, 20'h00A28, 20'h00528, 20'h002A8, 20'h00168, 20'h00128,
        20'h000A8, 20'h00068};
    localparam logic [19:0] SINC_FIRST [RATE_CODES] = '{
        20'h4B041, 20'h25841, 20'h12C41, 20'h0B441, 20'h09641, 20'h03C41,
        20'h03239, 20'h01E41, 20'h00F41, 20'h007C1, 20'h00401, 20'h00328,
        20'h001A8, 20'h000E8};
    localparam logic [19:0] DATA_PERIOD [RATE_CODES] = '{
        20'h19000, 20'h0C800, 20'h06400, 20'h03C00, 20'h03200, 20'h01400,
        20'h010A8, 20'h00A00, 20'h00500, 20'h00280, 20'h00140, 20'h00100,
        20'h00080, 20'h00040};
    localparam logic [19:0] DELAY_TICKS [8] = '{
        20'h0000E, 20'h00019, 20'h00040, 20'h00100,
        20'h00400, 20'h00800, 20'h01000, 20'h00001};

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_SAMPLE} seq_state_t;

    typedef struct packed {
        logic startCmd;
        logic wrEn;
        logic [4:0] addr;
        logic [7:0] wrData;
    } serial_req_t;

    typedef struct packed {
        logic [3:0] excitationMagnitude;
        logic [3:0] firstSourceRoute;
        logic [3:0] secondSourceRoute;
        logic biasTwelfth;
        logic [6:0] biasPinEnables;
        logic [2:0] monitorSelect;
        logic tempSensorOn;
        logic inputsConnected;
        logic polarityReversed;
    } frontend_t;

endpackage : adc_chop_pkg

/* File: serial_port.sv */
`timescale 1ns/100ps
module serial_port import adc_chop_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstSync_n,
    input wire logic clkEn,
    input wire logic csPin_n,
    input wire logic sclkPin,
    input wire logic dinPin,
    input wire logic [7:0] rdData,
    output logic doutPin,
    output logic doutEn,
    output serial_req_t req
);
    logic [2:0] meta_q, sync_q;
    logic sclkPrev_q;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shiftIn_q, shiftIn_d, op_q, op_d, shiftOut_q, shiftOut_d;
    logic dout_q, dout_d;
    serial_req_t req_q, req_d;
    logic csLow, sclk, din, fall, rise, isRead, isWrite;
    logic [7:0] inByte;

    // Pins come from the host's domain
    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            meta_q <= 3'h1;
            sync_q <= 3'h1;
            sclkPrev_q <= 1'b0;
        end else if (clkEn) begin
            meta_q <= {dinPin, sclkPin, csPin_n};
            sync_q <= meta_q;
            sclkPrev_q <= sync_q[1];
        end
    end

    assign csLow = !sync_q[0];
    assign sclk = sync_q[1];
    assign din = sync_q[2];
    assign fall = csLow && sclkPrev_q && !sclk;
    assign rise = csLow && !sclkPrev_q && sclk;
    assign inByte = {shiftIn_q[6:0], din};
    assign isRead = op_q[7:5] == OP_RREG_TOP;
    assign isWrite = op_q[7:5] == OP_WREG_TOP;

    always_comb begin
        bitCnt_d = bitCnt_q;
        shiftIn_d = shiftIn_q;
        op_d = op_q;
        shiftOut_d = shiftOut_q;
        dout_d = dout_q;
        req_d = req_q;
        req_d.startCmd = 1'b0;
        req_d.wrEn = 1'b0;
        if (!csLow) begin
            bitCnt_d = 4'h0;
            dout_d = 1'b0;
        end else if (fall) begin
            shiftIn_d = inByte;
            bitCnt_d = bitCnt_q + 4'h1;
            // Seventh falling edge of the start opcode begins converting
            if (bitCnt_q == 4'h6 && inByte[6:0] == OP_START[7:1]) begin
                req_d.startCmd = 1'b1;
            end
            if (bitCnt_q == 4'h7) begin
                op_d = inByte;
                req_d.addr = inByte[4:0];
                if (inByte[7:5] != OP_RREG_TOP &&
                        inByte[7:5] != OP_WREG_TOP) begin
                    bitCnt_d = 4'h0;
                end
            end
            if (bitCnt_q == 4'hF && isWrite) begin
                req_d.wrEn = 1'b1;
                req_d.wrData = inByte;
            end
        end else if (rise && bitCnt_q >= 4'h8) begin
            // Data changes on rising edges, host samples on falling
            if (bitCnt_q == 4'h8) begin
                dout_d = isRead && rdData[7];
                shiftOut_d = {rdData[6:0], 1'b0};
            end else begin
                dout_d = isRead && shiftOut_q[7];
                shiftOut_d = {shiftOut_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bitCnt_q <= 4'h0;
            shiftIn_q <= 8'h00;
            op_q <= 8'h00;
            shiftOut_q <= 8'h00;
            dout_q <= 1'b0;
            req_q <= '0;
        end else if (clkEn) begin
            bitCnt_q <= bitCnt_d;
            shiftIn_q <= shiftIn_d;
            op_q <= op_d;
            shiftOut_q <= shiftOut_d;
            dout_q <= dout_d;
            req_q <= req_d;
        end
    end

    assign req = req_q;
    assign doutPin = dout_q;
    assign doutEn = csLow;

endmodule : serial_port

/* File: adc_chop_monitor.sv */
`timescale 1ns/100ps
module adc_chop_monitor import adc_chop_pkg::*; #(
    parameter int SAMPLE_WIDTH = 16,
    parameter int ADC_CLK_KHZ = ADC_CLK_KHZ_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic csPin_n,
    input wire logic doutEn,
    input wire logic drdyPin_n,
    input wire logic signed [SAMPLE_WIDTH-1:0] dataOut,
    input wire logic dataReady,
    input wire logic converting,
    input wire frontend_t frontend
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Results are far apart at every rate
    sequence quietAfter;
        !dataReady [*8];
    endsequence
    sequence busyBefore;
        $past(converting);
    endsequence

    a_ready_single_pulse: assert property (dataReady |=> quietAfter)
        else $error("result pulse too long");
    a_result_holds: assert property (
        !dataReady |-> $stable(dataOut))
        else $error("result changed without pulse");
    a_drdy_on_result: assert property (
        dataReady |-> ##[0:1] !drdyPin_n)
        else $error("data ready pin not low after result");
    a_result_in_conv: assert property (dataReady |-> busyBefore)
        else $error("result without conversion");
    a_start_drdy_high: assert property (
        $rose(converting) |-> ##[0:2] drdyPin_n)
        else $error("data ready pin low after start");
    a_temp_code: assert property (
        frontend.tempSensorOn == (frontend.monitorSelect == 3'h2))
        else $error("sensor flag disagrees with monitor code");
    a_temp_disconnect: assert property (
        frontend.tempSensorOn |-> !frontend.inputsConnected)
        else $error("inputs connected during sensor read");
    a_dout_released: assert property (csPin_n [*4] |-> !doutEn)
        else $error("data out driven while deselected");
    c_chop_result: cover property (dataReady && frontend.polarityReversed);
endmodule : adc_chop_monitor

bind adc_chop_frontend adc_chop_monitor #(
    .SAMPLE_WIDTH(SAMPLE_WIDTH),
    .ADC_CLK_KHZ(ADC_CLK_KHZ)
) u_adc_chop_monitor (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .csPin_n(csPin_n),
    .doutEn(doutEn),
    .drdyPin_n(drdyPin_n),
    .dataOut(dataOut),
    .dataReady(dataReady),
    .converting(converting),
    .frontend(frontend)
);

/* File: spi_host.sv */
`timescale 1ns/100ps
module spi_host import adc_chop_pkg::*; (
    input wire logic sys_clk,
    input wire logic doutPin,
    output logic csPin_n,
    output logic sclkPin,
    output logic dinPin
);
    // Five cycles a phase leaves margin over the three-cycle minimum
    localparam int HALF = 5;
    time fall7Time;
    initial begin
        csPin_n = 1'b1;
        sclkPin = 1'b0;
        dinPin = 1'b1;
        fall7Time = 0;
    end
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        csPin_n = 1'b0;
        repeat (HALF) @(negedge sys_clk);
        for (int i = 0; i < 16; i++) begin
            sclkPin = 1'b1;
            dinPin = tx[15-i];
            repeat (HALF) @(negedge sys_clk);
            if (i >= 8) rx = {rx[6:0], doutPin};
            sclkPin = 1'b0;
            if (i == 6) fall7Time = $time;
            repeat (HALF) @(negedge sys_clk);
        end
        csPin_n = 1'b1;
        dinPin = ~dinPin;
        repeat (HALF) @(negedge sys_clk);
    endtask : xfer
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer({OP_WREG_TOP, a, d}, r);
    endtask : wr_reg
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        xfer({OP_RREG_TOP, a, 8'h00}, d);
    endtask : rd_reg
    // Second byte is an ignored opcode
    task automatic start_cmd();
        logic [7:0] r;
        xfer({OP_START, 8'h00}, r);
    endtask : start_cmd
endmodule : spi_host

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench import adc_chop_pkg::*; ;
    localparam int SW = 16;
    localparam int ADC_KHZ = 80000;
    localparam int TCK = SYS_CLK_KHZ * MOD_CLKS / ADC_KHZ;
    localparam logic signed [SW-1:0] VIN = 16'sh7000;
    localparam logic signed [SW-1:0] OFS = 16'sh0800;
    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [7:0] data;
        logic [7:0] expRd;
    } row_t;
    localparam int NROWS = 13;
    // Reference assumed on in the analog part
    // Gain stays 1 while the sensor is selected
    row_t rows [NROWS] = '{
        '{1'b0, 5'h03, 8'h00, 8'h00}, '{1'b0, 5'h04, 8'h00, 8'h14},
        '{1'b0, 5'h06, 8'h00, 8'h00}, '{1'b0, 5'h07, 8'h00, 8'hFF},
        '{1'b0, 5'h08, 8'h00, 8'h00}, '{1'b0, 5'h09, 8'h00, 8'h10},
        '{1'b1, 5'h05, 8'hAA, 8'h00}, '{1'b1, 5'h06, 8'h0A, 8'h0A},
        '{1'b1, 5'h07, 8'h53, 8'h53}, '{1'b1, 5'h07, 8'h77, 8'h77},
        '{1'b1, 5'h08, 8'hFF, 8'hFF}, '{1'b1, 5'h08, 8'h01, 8'h01},
        '{1'b1, 5'h09, 8'h50, 8'h50}};
    logic sys_clk, rst_n, clkEn, startPin, csPin_n, sclkPin, dinPin;
    logic doutPin, doutEn, drdyPin_n, dataReady, converting;
    logic signed [SW-1:0] convSample, dataOut;
    frontend_t frontend;
    int fails, cmp_count, cycles, n, n0;
    logic [7:0] shadow [32];
    logic [7:0] rx;

    adc_chop_frontend #(.SAMPLE_WIDTH(SW), .ADC_CLK_KHZ(ADC_KHZ))
        u_adc_chop_frontend (.sys_clk(sys_clk), .rst_n(rst_n),
        .clkEn(clkEn), .startPin(startPin), .csPin_n(csPin_n),
        .sclkPin(sclkPin), .dinPin(dinPin), .doutPin(doutPin),
        .doutEn(doutEn), .drdyPin_n(drdyPin_n), .convSample(convSample),
        .dataOut(dataOut), .dataReady(dataReady),
        .converting(converting), .frontend(frontend));
    // Released data line reads inverted so a late sample shows up
    spi_host u_spi_host (.sys_clk(sys_clk),
        .doutPin(doutEn ? doutPin : !doutPin),
        .csPin_n(csPin_n), .sclkPin(sclkPin), .dinPin(dinPin));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Offset survives only if the pair is not differenced
    always @(negedge sys_clk) begin
        convSample <= frontend.polarityReversed ? OFS - VIN : VIN + OFS;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 40000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic init_shadow();
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[5'h04] = 8'h14;
        shadow[5'h07] = 8'hFF;
        shadow[5'h09] = 8'h10;
    endtask : init_shadow
    function automatic frontend_t fe_exp();
        frontend_t f;
        f.excitationMagnitude = shadow[5'h06][3:0];
        f.firstSourceRoute = shadow[5'h07][3:0];
        f.secondSourceRoute = shadow[5'h07][7:4];
        f.biasTwelfth = shadow[5'h08][7];
        f.biasPinEnables = shadow[5'h08][6:0];
        f.monitorSelect = shadow[5'h09][7:5];
        f.tempSensorOn = (shadow[5'h09][7:5] == 3'h2);
        f.inputsConnected = !f.tempSensorOn;
        f.polarityReversed = 1'b0;
        return f;
    endfunction : fe_exp
    task automatic wait_ready(output int cnt);
        cnt = 0;
        do begin
            @(negedge sys_clk);
            cnt++;
        end while (dataReady !== 1'b1 && cnt < 3000);
    endtask : wait_ready
    task automatic check_win(input string what, input int cnt,
            input int lo, input int span);
        check(what, (cnt >= lo && cnt <= lo + span), 1'b1);
    endtask : check_win

    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        startPin = 1'b0;
        convSample = '0;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        init_shadow();
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < NROWS; i++) begin
            if (rows[i].wr) u_spi_host.wr_reg(rows[i].addr, rows[i].data);
            u_spi_host.rd_reg(rows[i].addr, rx);
            shadow[rows[i].addr] = rows[i].expRd;
            check("register", rx, rows[i].expRd);
            check("fe", frontend, fe_exp());
        end
        u_spi_host.wr_reg(REG_DRATE, 8'h1D);
        startPin = 1'b1;
        wait_ready(n);
        check_win("first plain", n, (14 + 104) * TCK, 8);
        check("plain data", dataOut, VIN + OFS);
        wait_ready(n);
        check_win("next plain", n, 64 * TCK, 3);
        startPin = 1'b0;
        u_spi_host.wr_reg(REG_DRATE, 8'h9D);
        startPin = 1'b1;
        wait_ready(n);
        check_win("1st chop", n, 2 * 118 * TCK, 8);
        check("chop data", dataOut, VIN);
        startPin = 1'b0;
        for (int k = 0; k < 2; k++) begin
            wait_ready(n);
            check_win("next chop", n, 118 * TCK, 3);
            check("chop pair", dataOut, VIN);
        end
        startPin = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("restart ready", drdyPin_n, 1'b1);
        wait_ready(n);
        check_win("restart chop", n + 6, 2 * 118 * TCK, 8);
        startPin = 1'b0;
        u_spi_host.wr_reg(REG_GAIN, 8'hE0);
        u_spi_host.wr_reg(REG_DRATE, 8'hAD);
        u_spi_host.start_cmd();
        n0 = ($time - u_spi_host.fall7Time) / 100;
        wait_ready(n);
        check_win("first sinc", n0 + n, 2 * 233 * TCK, 8);
        check("sinc data", dataOut, VIN);
        repeat (20) @(negedge sys_clk);
        check("single idle", converting, 1'b0);
        // Plain sinc single shot, rate code past the table, clock frozen
        u_spi_host.wr_reg(REG_DRATE, 8'h2F);
        startPin = 1'b1;
        repeat (100) @(negedge sys_clk);
        check("pin busy", converting, 1'b1);
        clkEn = 1'b0;
        repeat (50) @(negedge sys_clk);
        clkEn = 1'b1;
        wait_ready(n);
        check_win("plain sinc", n + 150, 233 * TCK + 50, 8);
        check("plain sinc data", dataOut, VIN + OFS);
        check("plain idle", converting, 1'b0);
        startPin = 1'b0;
        repeat (4) @(negedge sys_clk);
        startPin = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b0;
        @(negedge sys_clk);
        check("reset busy", converting, 1'b0);
        check("reset drdy", drdyPin_n, 1'b1);
        check("reset data", dataOut, '0);
        check("reset fe", frontend, '0);
        rst_n = 1'b1;
        init_shadow();
        repeat (4) @(negedge sys_clk);
        check("reset fe values", frontend, fe_exp());
        u_spi_host.rd_reg(REG_DRATE, rx);
        check("reset rate", rx, 8'h14);
        give_verdict();
    end
endmodule : testbench
